/* File: rxbm_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module rxbm_divider
	import rxbm_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire logic WE_LOW_I,
	input wire logic WE_HIGH_I,
	input wire logic [7:0] D_I,
	output logic [15:0] HOLD_O,
	output logic [15:0] ACTIVE_O
);
	rxbm_div_state_type state;
	rxbm_div_state_type next_state;
	logic [15:0] next_hold;
	logic [15:0] next_active;

	// low byte first, high byte commits word
	always_comb begin
		next_state = state;
		next_hold = HOLD_O;
		next_active = ACTIVE_O;
		if (CE_I) begin
			if (WE_LOW_I) begin
				next_hold[7:0] = D_I; // [RULE12]
			end
			if (WE_HIGH_I) begin
				next_hold[15:8] = D_I; // [RULE12]
			end
			case (state)
				DIV_IDLE: begin
					if (WE_LOW_I) begin
						next_state = DIV_LOW_HELD;
					end
					if (WE_HIGH_I) begin
						next_active = {D_I, HOLD_O[7:0]}; // [RULE14]
					end
				end
				DIV_LOW_HELD: begin
					if (WE_HIGH_I) begin
						next_active = {D_I, HOLD_O[7:0]}; // [RULE14]
						next_state = DIV_IDLE;
					end
				end
				default: begin
					next_state = DIV_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state <= DIV_IDLE;
			HOLD_O <= {RESET_DIV_HIGH, RESET_DIV_LOW}; // [RULE13]
			ACTIVE_O <= {RESET_DIV_HIGH, RESET_DIV_LOW}; // [RULE13]
		end else begin
			state <= next_state;
			HOLD_O <= next_hold;
			ACTIVE_O <= next_active;
		end
	end
endmodule
`default_nettype wire

/* File: rxbm_pkg.sv */
// Contract
// RULE1: read-only product code high byte at 0x005
// RULE2: bias bits 7,6 enable RF main, synthesizer
// RULE3: bias bits 4,3,2 enable attenuator, LNA2, LNA1
// RULE4: bias bits 1,0 enable LO, IF amplifiers
// RULE5: bias register 0x100, reset 0xdf, bit5 zero
// RULE6: mute select register 0x101, one bit each
// RULE7: mute select resets 0xbf, bit5 writable
// RULE8: power-on select register 0x102, six blocks
// RULE9: power-on select resets 0xff, bits 5,0 writable
// RULE10: 0x103 bit0 mutes on lock loss
// RULE11: divider word 16 bits at 0x200/0x201
// RULE12: divider word double buffered behind holding stage
// RULE13: divider resets low 0x90, high 0x01
// RULE14: both divider bytes move to active together
// RULE15: lock input high means PLL locked
package rxbm_pkg;
	localparam logic [11:0] ADDR_PRODUCT_HIGH = 12'h005;
	localparam logic [11:0] ADDR_BIAS = 12'h100;
	localparam logic [11:0] ADDR_MUTE_SEL = 12'h101;
	localparam logic [11:0] ADDR_ON_SEL = 12'h102;
	localparam logic [11:0] ADDR_LOCK_SILENCE = 12'h103;
	localparam logic [11:0] ADDR_DIV_LOW = 12'h200;
	localparam logic [11:0] ADDR_DIV_HIGH = 12'h201;
	localparam logic [7:0] RESET_BIAS = 8'hdf;
	localparam logic [7:0] BIAS_WRITE_MASK = 8'hdf;
	localparam logic [7:0] RESET_MUTE_SEL = 8'hbf;
	localparam logic [7:0] RESET_ON_SEL = 8'hff;
	localparam logic [7:0] RESET_LOCK_SILENCE = 8'h01;
	localparam logic [7:0] LOCK_SILENCE_MASK = 8'h01;
	localparam logic [7:0] RESET_DIV_LOW = 8'h90;
	localparam logic [7:0] RESET_DIV_HIGH = 8'h01;
	// product code value is arbitrary
	localparam logic [7:0] PRODUCT_CODE_HIGH = 8'h5a;
	localparam int BIT_RF_MAIN = 7;
	localparam int BIT_SYNTH = 6;
	localparam int BIT_ATTEN = 4;
	localparam int BIT_LNA2 = 3;
	localparam int BIT_LNA1 = 2;
	localparam int BIT_LO_AMP = 1;
	localparam int BIT_IF_AMP = 0;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [7:0] wdata;
	} rxbm_req_type;

	typedef struct packed {
		logic rf_main;
		logic synthesizer;
		logic attenuator;
		logic low_noise_amp2;
		logic low_noise_amp1;
		logic lo_amplifier;
		logic if_amplifier;
	} rxbm_blocks_type;

	typedef enum logic [0:0] {
		DIV_IDLE = 1'b0,
		DIV_LOW_HELD = 1'b1
	} rxbm_div_state_type;
endpackage

/* File: rxbm_reg8.sv */
`timescale 1ns/1ps
`default_nettype none
module rxbm_reg8 #(
	parameter logic [7:0] RESET_VALUE = 8'h00,
	parameter logic [7:0] WRITE_MASK = 8'hff
) (
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire logic WE_I,
	input wire logic [7:0] D_I,
	output logic [7:0] Q_O
);
	logic [7:0] next_q;

	always_comb begin
		next_q = Q_O;
		if (CE_I && WE_I) begin
			next_q = D_I & WRITE_MASK;
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			Q_O <= RESET_VALUE;
		end else begin
			Q_O <= next_q;
		end
	end
endmodule
`default_nettype wire

/* File: rxbm_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module rxbm_regs
	import rxbm_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire rxbm_pkg::rxbm_req_type REQ_I,
	output logic [7:0] RDATA_O,
	output logic RVALID_O,
	input wire logic LOCKED_I,
	output rxbm_pkg::rxbm_blocks_type BIAS_EN_O,
	output rxbm_pkg::rxbm_blocks_type MUTE_SEL_O,
	output rxbm_pkg::rxbm_blocks_type POWERON_SEL_O,
	output logic UNLOCK_MUTE_O,
	output logic [15:0] FEEDBACK_DIVIDE_O
);
	logic [7:0] block_bias_enable;
	logic [7:0] mute_select;
	logic [7:0] power_on_select;
	logic [7:0] lock_loss_silence;
	logic [15:0] div_hold;
	logic [7:0] read_mux;
	logic [7:0] next_rdata;
	logic next_rvalid;
	logic [7:0] rdata;
	logic rvalid;
	logic next_unlock_mute;
	logic unlock_mute;
	logic we_bias;
	logic we_mute;
	logic we_on;
	logic we_lock;
	logic we_div_low;
	logic we_div_high;

	assign we_bias = REQ_I.wr && (REQ_I.addr == ADDR_BIAS);
	assign we_mute = REQ_I.wr && (REQ_I.addr == ADDR_MUTE_SEL);
	assign we_on = REQ_I.wr && (REQ_I.addr == ADDR_ON_SEL);
	assign we_lock = REQ_I.wr && (REQ_I.addr == ADDR_LOCK_SILENCE);
	assign we_div_low = REQ_I.wr && (REQ_I.addr == ADDR_DIV_LOW); // [RULE11]
	assign we_div_high = REQ_I.wr && (REQ_I.addr == ADDR_DIV_HIGH); // [RULE11]

	// bit 5 held at zero
	rxbm_reg8 #(
		.RESET_VALUE(RESET_BIAS),
		.WRITE_MASK(BIAS_WRITE_MASK)
	) u_bias ( // [RULE5]
		.CLK_I(CLK_I),
		.RST_I(RST_I),
		.CE_I(CE_I),
		.WE_I(we_bias),
		.D_I(REQ_I.wdata),
		.Q_O(block_bias_enable)
	);

	rxbm_reg8 #(
		.RESET_VALUE(RESET_MUTE_SEL),
		.WRITE_MASK(8'hff)
	) u_mute ( // [RULE6] [RULE7]
		.CLK_I(CLK_I),
		.RST_I(RST_I),
		.CE_I(CE_I),
		.WE_I(we_mute),
		.D_I(REQ_I.wdata),
		.Q_O(mute_select)
	);

	rxbm_reg8 #(
		.RESET_VALUE(RESET_ON_SEL),
		.WRITE_MASK(8'hff)
	) u_on ( // [RULE8] [RULE9]
		.CLK_I(CLK_I),
		.RST_I(RST_I),
		.CE_I(CE_I),
		.WE_I(we_on),
		.D_I(REQ_I.wdata),
		.Q_O(power_on_select)
	);

	rxbm_reg8 #(
		.RESET_VALUE(RESET_LOCK_SILENCE),
		.WRITE_MASK(LOCK_SILENCE_MASK)
	) u_lock ( // [RULE10]
		.CLK_I(CLK_I),
		.RST_I(RST_I),
		.CE_I(CE_I),
		.WE_I(we_lock),
		.D_I(REQ_I.wdata),
		.Q_O(lock_loss_silence)
	);

	rxbm_divider u_div (
		.CLK_I(CLK_I),
		.RST_I(RST_I),
		.CE_I(CE_I),
		.WE_LOW_I(we_div_low),
		.WE_HIGH_I(we_div_high),
		.D_I(REQ_I.wdata),
		.HOLD_O(div_hold),
		.ACTIVE_O(FEEDBACK_DIVIDE_O)
	);

	// bias enables to block outputs
	always_comb begin
		BIAS_EN_O.rf_main = block_bias_enable[BIT_RF_MAIN]; // [RULE2]
		BIAS_EN_O.synthesizer = block_bias_enable[BIT_SYNTH]; // [RULE2]
		BIAS_EN_O.attenuator = block_bias_enable[BIT_ATTEN]; // [RULE3]
		BIAS_EN_O.low_noise_amp2 = block_bias_enable[BIT_LNA2]; // [RULE3]
		BIAS_EN_O.low_noise_amp1 = block_bias_enable[BIT_LNA1]; // [RULE3]
		BIAS_EN_O.lo_amplifier = block_bias_enable[BIT_LO_AMP]; // [RULE4]
		BIAS_EN_O.if_amplifier = block_bias_enable[BIT_IF_AMP]; // [RULE4]
	end

	always_comb begin
		MUTE_SEL_O.rf_main = mute_select[BIT_RF_MAIN]; // [RULE6]
		MUTE_SEL_O.synthesizer = mute_select[BIT_SYNTH];
		MUTE_SEL_O.attenuator = mute_select[BIT_ATTEN];
		MUTE_SEL_O.low_noise_amp2 = mute_select[BIT_LNA2];
		MUTE_SEL_O.low_noise_amp1 = mute_select[BIT_LNA1];
		MUTE_SEL_O.lo_amplifier = mute_select[BIT_LO_AMP];
		MUTE_SEL_O.if_amplifier = mute_select[BIT_IF_AMP];
	end

	// no on-select bit for if amplifier
	always_comb begin
		POWERON_SEL_O.rf_main = power_on_select[BIT_RF_MAIN]; // [RULE8]
		POWERON_SEL_O.synthesizer = power_on_select[BIT_SYNTH];
		POWERON_SEL_O.attenuator = power_on_select[BIT_ATTEN];
		POWERON_SEL_O.low_noise_amp2 = power_on_select[BIT_LNA2];
		POWERON_SEL_O.low_noise_amp1 = power_on_select[BIT_LNA1];
		POWERON_SEL_O.lo_amplifier = power_on_select[BIT_LO_AMP];
		POWERON_SEL_O.if_amplifier = 1'b0;
	end

	// read decode
	always_comb begin
		case (REQ_I.addr)
			ADDR_PRODUCT_HIGH: read_mux = PRODUCT_CODE_HIGH; // [RULE1]
			ADDR_BIAS: read_mux = block_bias_enable; // [RULE5]
			ADDR_MUTE_SEL: read_mux = mute_select;
			ADDR_ON_SEL: read_mux = power_on_select;
			ADDR_LOCK_SILENCE: read_mux = lock_loss_silence;
			ADDR_DIV_LOW: read_mux = div_hold[7:0];
			ADDR_DIV_HIGH: read_mux = div_hold[15:8];
			default: read_mux = 8'h00;
		endcase
	end

	always_comb begin
		next_rdata = rdata;
		next_rvalid = rvalid;
		next_unlock_mute = unlock_mute;
		if (CE_I) begin
			next_rvalid = REQ_I.rd;
			if (REQ_I.rd) begin
				next_rdata = read_mux;
			end
			next_unlock_mute = lock_loss_silence[0] && !LOCKED_I; // [RULE10] [RULE15]
		end
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
			unlock_mute <= 1'b0;
		end else begin
			rdata <= next_rdata;
			rvalid <= next_rvalid;
			unlock_mute <= next_unlock_mute;
		end
	end

	assign RDATA_O = rdata;
	assign RVALID_O = rvalid;
	assign UNLOCK_MUTE_O = unlock_mute;
endmodule
`default_nettype wire

/* File: rxbm_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module rxbm_regs_bench;
	import rxbm_pkg::*;
	logic CLK_I = 0;
	logic RST_I = 1;
	logic CE_I = 1;
	logic LOCKED_I = 1;
	rxbm_req_type req = '0;
	logic [7:0] rdata;
	logic rvalid;
	logic unlock;
	rxbm_blocks_type bias, mute, pon;
	logic [15:0] fdiv;
	logic [15:0] w;
	logic [7:0] d;
	int fails = 0;
	int n_checks = 0;
	int cycles = 0;
	int seed = 32'ha61e;
	always #5 CLK_I = ~CLK_I;
	rxbm_regs dut (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .REQ_I(req), .RDATA_O(rdata), .RVALID_O(rvalid),
		.LOCKED_I(LOCKED_I), .BIAS_EN_O(bias), .MUTE_SEL_O(mute), .POWERON_SEL_O(pon),
		.UNLOCK_MUTE_O(unlock), .FEEDBACK_DIVIDE_O(fdiv));
	function automatic rxbm_blocks_type blk(input logic [7:0] v);
		return {v[7:6], v[4:0]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("checks=%0d fails=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// request stays up until the next task replaces it
	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		req = '{1'b1, 1'b0, a, v};
		@(posedge CLK_I);
		#1;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		req = '{1'b0, 1'b1, a, 8'h00};
		@(posedge CLK_I);
		#1;
		chk(16'(rvalid), 16'h0001);
		chk(16'(rdata), 16'(exp));
	endtask
	always @(posedge CLK_I) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		repeat (4) @(posedge CLK_I);
		#1 RST_I = 0;
		chk(fdiv, 16'h0190);
		chk(16'(bias), 16'h007f);
		rd(ADDR_PRODUCT_HIGH, PRODUCT_CODE_HIGH);
		rd(ADDR_BIAS, 8'hdf);
		rd(ADDR_MUTE_SEL, 8'hbf);
		rd(ADDR_ON_SEL, 8'hff);
		rd(ADDR_LOCK_SILENCE, 8'h01);
		rd(ADDR_DIV_LOW, 8'h90);
		rd(ADDR_DIV_HIGH, 8'h01);
		rd(12'h300, 8'h00);
		for (int i = 0; i < 40; i++) begin
			d = (i < 2) ? {8{i[0]}} : 8'($random(seed));
			LOCKED_I = d[3];
			wr(ADDR_PRODUCT_HIGH, d);
			chk(16'(rvalid), 16'h0000);
			wr(ADDR_BIAS, d);
			wr(ADDR_MUTE_SEL, ~d);
			wr(ADDR_ON_SEL, d);
			wr(ADDR_LOCK_SILENCE, d);
			chk(16'(bias), 16'(blk(d)));
			chk(16'(mute), 16'(blk(~d)));
			chk(16'(pon), 16'(blk(d) & 7'h7e));
			w = fdiv;
			wr(ADDR_DIV_LOW, ~d);
			chk(fdiv, w);
			wr(ADDR_DIV_HIGH, d);
			chk(fdiv, {d, ~d});
			rd(ADDR_PRODUCT_HIGH, PRODUCT_CODE_HIGH);
			rd(ADDR_BIAS, d & BIAS_WRITE_MASK);
			rd(ADDR_MUTE_SEL, ~d);
			rd(ADDR_ON_SEL, d);
			rd(ADDR_LOCK_SILENCE, d & LOCK_SILENCE_MASK);
			rd(ADDR_DIV_LOW, ~d);
			rd(ADDR_DIV_HIGH, d);
			chk(16'(unlock), 16'(d[0] & ~d[3]));
		end
		// disabled clock must leave registers alone
		CE_I = 0;
		w = fdiv;
		wr(ADDR_BIAS, ~d);
		wr(ADDR_DIV_HIGH, ~d);
		chk(16'(bias), 16'(blk(d)));
		chk(fdiv, w);
		CE_I = 1;
		rd(ADDR_BIAS, d & BIAS_WRITE_MASK);
		req = '0;
		RST_I = 1;
		@(posedge CLK_I);
		#1 RST_I = 0;
		chk(fdiv, 16'h0190);
		chk(16'(mute), 16'h005f);
		chk(16'(pon), 16'h007e);
		chk(16'(unlock), 16'h0000);
		rd(ADDR_LOCK_SILENCE, 8'h01);
		rd(ADDR_DIV_LOW, 8'h90);
		give_verdict();
	end
endmodule
`default_nettype wire

/* File: rxbm_regs_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module rxbm_chk
	import rxbm_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire rxbm_pkg::rxbm_req_type REQ_I,
	input wire logic [7:0] RDATA_O,
	input wire logic RVALID_O,
	input wire logic LOCKED_I,
	input wire rxbm_pkg::rxbm_blocks_type BIAS_EN_O,
	input wire rxbm_pkg::rxbm_blocks_type MUTE_SEL_O,
	input wire rxbm_pkg::rxbm_blocks_type POWERON_SEL_O,
	input wire logic UNLOCK_MUTE_O,
	input wire logic [15:0] FEEDBACK_DIVIDE_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	function automatic logic [6:0] pick(input logic [7:0] d);
		return {d[7:6], d[4:0]};
	endfunction
	// silence bit written, then a cycle without lock
	sequence arm_silence(logic v);
		CE_I && REQ_I.wr && REQ_I.addr == ADDR_LOCK_SILENCE && REQ_I.wdata[0] == v ##1 CE_I && !LOCKED_I;
	endsequence
	a_product_read: assert property (
		CE_I && REQ_I.rd && REQ_I.addr == ADDR_PRODUCT_HIGH |=> RVALID_O && RDATA_O == PRODUCT_CODE_HIGH)
		else $error("product code read wrong");
	a_bias_write: assert property (
		CE_I && REQ_I.wr && REQ_I.addr == ADDR_BIAS |=> BIAS_EN_O == pick($past(REQ_I.wdata)))
		else $error("bias enables wrong");
	a_mute_write: assert property (
		CE_I && REQ_I.wr && REQ_I.addr == ADDR_MUTE_SEL |=> MUTE_SEL_O == pick($past(REQ_I.wdata)))
		else $error("mute select wrong");
	a_on_write: assert property (
		CE_I && REQ_I.wr && REQ_I.addr == ADDR_ON_SEL |=> POWERON_SEL_O == (pick($past(REQ_I.wdata)) & 7'h7e))
		else $error("power-on select wrong");
	a_div_hold: assert property (
		CE_I && REQ_I.wr && REQ_I.addr == ADDR_DIV_LOW |=> $stable(FEEDBACK_DIVIDE_O))
		else $error("divider moved on low write");
	a_div_commit: assert property (
		CE_I && REQ_I.wr && REQ_I.addr == ADDR_DIV_HIGH |=> FEEDBACK_DIVIDE_O[15:8] == $past(REQ_I.wdata))
		else $error("divider high not committed");
	a_reset_state: assert property (
		$fell(RST_I) |-> FEEDBACK_DIVIDE_O == 16'h0190 && BIAS_EN_O == 7'h7f && MUTE_SEL_O == 7'h5f
		&& POWERON_SEL_O == 7'h7e && !RVALID_O)
		else $error("reset state wrong");
	a_unlock_mute: assert property (arm_silence(1'b1) |=> UNLOCK_MUTE_O)
		else $error("no mute on lock loss");
	a_unlock_quiet: assert property (arm_silence(1'b0) |=> !UNLOCK_MUTE_O)
		else $error("mute while disabled");
	a_locked_quiet: assert property (CE_I && LOCKED_I |=> !UNLOCK_MUTE_O)
		else $error("mute while locked");
	a_enable_freeze: assert property (!CE_I |=> $stable(BIAS_EN_O) && $stable(FEEDBACK_DIVIDE_O)
		&& $stable(MUTE_SEL_O) && $stable(RVALID_O) && $stable(UNLOCK_MUTE_O))
		else $error("state moved while disabled");
endmodule
bind rxbm_regs rxbm_chk chk (.CLK_I(CLK_I), .RST_I(RST_I), .CE_I(CE_I), .REQ_I(REQ_I), .RDATA_O(RDATA_O),
	.RVALID_O(RVALID_O), .LOCKED_I(LOCKED_I), .BIAS_EN_O(BIAS_EN_O), .MUTE_SEL_O(MUTE_SEL_O),
	.POWERON_SEL_O(POWERON_SEL_O), .UNLOCK_MUTE_O(UNLOCK_MUTE_O), .FEEDBACK_DIVIDE_O(FEEDBACK_DIVIDE_O));
`default_nettype wire
